// ==== cpfi_pkg.sv ====
`default_nettype none
package cpfi_pkg;
  // Port geometry
  localparam int PINS = 3;
  localparam int NUM_CH = 2;

  // Pin functions, two bits per pin in the function register
  typedef enum logic [1:0] {
    BIDIR_PIN_FUNCTION = 2'b00,
    INPUT_ONLY_FUNCTION = 2'b01,
    FAULT_OUT_FUNCTION = 2'b10,
    INHIBIT_IN_FUNCTION = 2'b11
  } cpfi_func_e;

  // Inhibit input modes; code 2'b11 behaves as off
  typedef enum logic [1:0] {
    INHIBIT_OFF_MODE = 2'b00,
    INHIBIT_LATCHING_MODE = 2'b01,
    INHIBIT_LIVE_MODE = 2'b10
  } cpfi_mode_e;

  // Register byte offsets
  localparam logic [7:0] REG_FUNC = 8'h00;
  localparam logic [7:0] REG_POL = 8'h04;
  localparam logic [7:0] REG_OUT = 8'h08;
  localparam logic [7:0] REG_IN = 8'h0C;
  localparam logic [7:0] REG_MODE = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  localparam logic [7:0] REG_CHAN = 8'h18;

  // Control write bits and status read bits at REG_CTRL
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_SHORTCUT_BIT = 1;
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_PROT_BIT = 1;
  localparam int ST_INHIBIT_BIT = 2;
  localparam int ST_DISABLED_BIT = 3;

  // Values after reset
  localparam logic [5:0] FUNC_RST = 6'h00;
  localparam logic [2:0] POL_RST = 3'h0;
  localparam logic [2:0] OUT_RST = 3'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [NUM_CH-1:0] CHAN_RST = '0;

  // Timing: 125 MHz clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int INHIBIT_LATENCY_US = 450;
  localparam int OFF_DELAY_MS = 45;
  // Longest times round down
  localparam int INHIBIT_LATENCY_CYC = (INHIBIT_LATENCY_US * 1000) / CLK_PERIOD_NS;
  localparam int OFF_DELAY_CYC = (OFF_DELAY_MS * 1000000) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ==== cpfi_lvl_if.sv ====
`default_nettype none
interface cpfi_lvl_if;
  // Filtered pin levels, pin 1 in bit 0
  logic [2:0] level;
  modport src (output level);
  modport dst (input level);
endinterface
`default_nettype wire

// ==== cpfi_pin_sync.sv ====
`default_nettype none
module cpfi_pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] pin_i,
  cpfi_lvl_if.src lvl
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] level;
  } cpfi_sync_s;

  cpfi_sync_s st;
  cpfi_sync_s next_st;

  // Three-stage chain; level moves only when stages two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int k = 0; k < 3; k++) begin
      if (st.s2[k] == st.s3[k]) begin
        next_st.level[k] = st.s3[k];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      next_st_reset: st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lvl.level = st.level;

  property p_sync_agree;
    @(posedge clk_i) disable iff (rst_i)
    (st.s2[2] == st.s3[2]) |=> (st.level[2] == $past(st.s3[2]));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("level ignores agreed input");
endmodule
`default_nettype wire

// ==== cpfi_top.sv ====
// Summary of operation
// - Each pin bidirectional, own polarity select
// - Pin 3 bit 2, pin 1 bit 0
// - Positive polarity: bit 1 high, 0 low
// - Input field shows applied pin levels; code reads them through the polarity select, fault and inhibit pins read 0
// - Input-only pins ignore the output word
// - Fault on pin 1, pin 2 return
// - Overvoltage, overcurrent, overtemperature, inhibit raise fault
// - Fault holds until cause gone, cleared
// - Fault pin polarity selectable
// - Only pin 3 inhibits, level acting
// - Inhibit change seen under 450 us
// - Outputs start turning off within 45 ms
// - Inhibit mode kept in non-volatile storage
// - Latching: true edge disables, stays disabled
// - Live: outputs follow the inhibit level
// - Off mode ignores inhibit input
// - Inhibit shortcut sets positive polarity
// - Remove inhibit, then clear restores outputs
// - Chain stays faulted; live clear releases
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`default_nettype none
module cpfi_top #(
  parameter int INHIBIT_LATENCY_CYC = cpfi_pkg::INHIBIT_LATENCY_CYC,
  parameter int OFF_DELAY_CYC = cpfi_pkg::OFF_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [2:0] pin_i,
  output logic [2:0] pin_o,
  output logic [2:0] pin_oe_o,
  input wire logic [cpfi_pkg::NUM_CH-1:0] ov_i,
  input wire logic [cpfi_pkg::NUM_CH-1:0] oc_i,
  input wire logic [cpfi_pkg::NUM_CH-1:0] ot_i,
  output logic [cpfi_pkg::NUM_CH-1:0] chan_en_o,
  input wire logic [1:0] nv_mode_i,
  output logic [1:0] nv_mode_o,
  output logic nv_store_o
);
  typedef struct packed {
    logic [5:0] func;
    logic [2:0] pol;
    logic [2:0] out_data;
    logic [1:0] mode;
    logic [cpfi_pkg::NUM_CH-1:0] chan_on;
    logic prot;
    logic fault;
    logic inhibit_prev;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic [cpfi_pkg::NUM_CH-1:0] chan_en;
    logic ack;
    logic [31:0] rdata;
    logic nv_loaded;
    logic nv_store;
    logic [31:0] off_wait;
  } cpfi_state_s;

  cpfi_state_s st;
  cpfi_state_s next_st;

  cpfi_lvl_if lvl ();

  cpfi_pin_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_i),
    .lvl(lvl)
  );

  // Effective function of pin k; illegal choices fall back to input only
  function automatic logic [1:0] eff_func(input logic [5:0] f, input int k);
    logic [1:0] sel;
    sel = f[2*k +: 2];
    if (k == 1 && f[1:0] == cpfi_pkg::FAULT_OUT_FUNCTION) begin
      sel = cpfi_pkg::INPUT_ONLY_FUNCTION;
    end else if (sel == cpfi_pkg::FAULT_OUT_FUNCTION && k != 0) begin
      sel = cpfi_pkg::INPUT_ONLY_FUNCTION;
    end else if (sel == cpfi_pkg::INHIBIT_IN_FUNCTION && k != 2) begin
      sel = cpfi_pkg::INPUT_ONLY_FUNCTION;
    end
    return sel;
  endfunction

  // Logical input word for pins in bidirectional or input-only function
  function automatic logic [2:0] in_word(input logic [5:0] f, input logic [2:0] pol,
                                         input logic [2:0] lv);
    logic [2:0] w;
    logic [1:0] ef;
    w = 3'h0;
    for (int k = 0; k < 3; k++) begin
      ef = eff_func(f, k);
      if (ef == cpfi_pkg::BIDIR_PIN_FUNCTION || ef == cpfi_pkg::INPUT_ONLY_FUNCTION) begin
        w[k] = lv[k] ^ pol[k];
      end
    end
    return w;
  endfunction

  logic wr_go;
  logic rd_go;
  logic clear_req;
  logic inhibit_sel;
  logic inhibit_true;
  logic cause_own;
  logic live_hold;
  logic disabled;
  logic mode_valid;

  // Bus qualifiers and protection causes
  always_comb begin
    wr_go = cyc_i && stb_i && we_i && !st.ack && sel_i[0];
    rd_go = cyc_i && stb_i && !we_i && !st.ack;
    clear_req = wr_go && adr_i == cpfi_pkg::REG_CTRL && dat_i[cpfi_pkg::CTRL_CLEAR_BIT];
    mode_valid = st.mode == cpfi_pkg::INHIBIT_LATCHING_MODE ||
                 st.mode == cpfi_pkg::INHIBIT_LIVE_MODE;
    inhibit_sel = eff_func(st.func, 2) == cpfi_pkg::INHIBIT_IN_FUNCTION;
    inhibit_true = inhibit_sel && mode_valid && (lvl.level[2] ^ st.pol[2]);
    cause_own = |(ov_i | oc_i | ot_i);
    live_hold = st.mode == cpfi_pkg::INHIBIT_LIVE_MODE && inhibit_true;
    disabled = st.prot || live_hold;
  end

  // Next state: registers, protection, pins and bus answer
  always_comb begin
    next_st = st;
    next_st.nv_store = 1'b0;
    next_st.ack = cyc_i && stb_i && !st.ack;
    next_st.inhibit_prev = inhibit_true;

    // Load the stored inhibit mode once after reset
    if (!st.nv_loaded) begin
      next_st.nv_loaded = 1'b1;
      if (nv_mode_i == cpfi_pkg::INHIBIT_LATCHING_MODE ||
          nv_mode_i == cpfi_pkg::INHIBIT_LIVE_MODE) begin
        next_st.mode = nv_mode_i;
      end else begin
        next_st.mode = cpfi_pkg::INHIBIT_OFF_MODE;
      end
    end

    // Register writes through byte lane 0
    if (wr_go) begin
      case (adr_i)
        cpfi_pkg::REG_FUNC: begin
          next_st.func = dat_i[5:0];
        end
        cpfi_pkg::REG_POL: begin
          next_st.pol = dat_i[2:0];
        end
        cpfi_pkg::REG_OUT: begin
          next_st.out_data = dat_i[2:0];
        end
        cpfi_pkg::REG_MODE: begin
          next_st.mode = dat_i[1:0];
          next_st.nv_store = 1'b1;
        end
        cpfi_pkg::REG_CTRL: begin
          if (dat_i[cpfi_pkg::CTRL_SHORTCUT_BIT]) begin
            next_st.func[5:4] = cpfi_pkg::INHIBIT_IN_FUNCTION;
            next_st.pol[2] = 1'b0;
          end
        end
        cpfi_pkg::REG_CHAN: begin
          next_st.chan_on = dat_i[cpfi_pkg::NUM_CH-1:0];
        end
        default: begin
          next_st.rdata = st.rdata;
        end
      endcase
    end

    // Register reads; unmapped addresses read zero
    if (rd_go) begin
      next_st.rdata = 32'h0000_0000;
      case (adr_i)
        cpfi_pkg::REG_FUNC: next_st.rdata[5:0] = st.func;
        cpfi_pkg::REG_POL: next_st.rdata[2:0] = st.pol;
        cpfi_pkg::REG_OUT: next_st.rdata[2:0] = st.out_data;
        cpfi_pkg::REG_IN: next_st.rdata[2:0] = in_word(st.func, st.pol, lvl.level);
        cpfi_pkg::REG_MODE: next_st.rdata[1:0] = st.mode;
        cpfi_pkg::REG_CTRL: begin
          next_st.rdata[cpfi_pkg::ST_FAULT_BIT] = st.fault;
          next_st.rdata[cpfi_pkg::ST_PROT_BIT] = st.prot;
          next_st.rdata[cpfi_pkg::ST_INHIBIT_BIT] = inhibit_true;
          next_st.rdata[cpfi_pkg::ST_DISABLED_BIT] = disabled;
        end
        cpfi_pkg::REG_CHAN: next_st.rdata[cpfi_pkg::NUM_CH-1:0] = st.chan_on;
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    // Clear is refused while a cause remains; a new cause wins over clear
    if (clear_req && !cause_own && !inhibit_true) begin
      next_st.prot = 1'b0;
    end
    if (cause_own) begin
      next_st.prot = 1'b1;
    end
    if (st.mode == cpfi_pkg::INHIBIT_LATCHING_MODE && inhibit_true && !st.inhibit_prev) begin
      next_st.prot = 1'b1;
    end

    // Fault level: latched protection plus a live inhibit
    next_st.fault = next_st.prot || live_hold;
    next_st.chan_en = next_st.chan_on &
                      ~{cpfi_pkg::NUM_CH{next_st.prot || live_hold}};

    // Pin drivers
    for (int k = 0; k < 3; k++) begin
      case (eff_func(next_st.func, k))
        cpfi_pkg::BIDIR_PIN_FUNCTION: begin
          next_st.pin_oe[k] = 1'b1;
          next_st.pin_out[k] = next_st.out_data[k] ^ next_st.pol[k];
        end
        cpfi_pkg::FAULT_OUT_FUNCTION: begin
          next_st.pin_oe[k] = 1'b1;
          next_st.pin_out[k] = next_st.fault ^ next_st.pol[k];
        end
        default: begin
          next_st.pin_oe[k] = 1'b0;
          next_st.pin_out[k] = 1'b0;
        end
      endcase
    end

    // Cycles spent with inhibit true while some output is still enabled
    if (inhibit_true && (|st.chan_en)) begin
      next_st.off_wait = st.off_wait + 32'h0000_0001;
    end else begin
      next_st.off_wait = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.func <= cpfi_pkg::FUNC_RST;
      st.pol <= cpfi_pkg::POL_RST;
      st.out_data <= cpfi_pkg::OUT_RST;
      st.mode <= cpfi_pkg::MODE_RST;
      st.chan_on <= cpfi_pkg::CHAN_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign pin_o = st.pin_out;
  assign pin_oe_o = st.pin_oe;
  assign chan_en_o = st.chan_en;
  assign nv_mode_o = st.mode;
  assign nv_store_o = st.nv_store;

  property p_bidir_pos;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && st.func[1:0] == cpfi_pkg::BIDIR_PIN_FUNCTION && !st.pol[0]) ##1
    (st.func[1:0] == cpfi_pkg::BIDIR_PIN_FUNCTION && !st.pol[0]) |->
    (pin_oe_o[0] && pin_o[0] == st.out_data[0]);
  endproperty
  a_bidir_pos: assert property (p_bidir_pos) else $error("bidir pin level wrong");

  property p_bidir_neg;
    @(posedge clk_i) disable iff (rst_i)
    (st.func[5:4] == cpfi_pkg::BIDIR_PIN_FUNCTION && st.pol[2]) ##1
    (st.func[5:4] == cpfi_pkg::BIDIR_PIN_FUNCTION && st.pol[2]) |->
    (pin_o[2] == !st.out_data[2]);
  endproperty
  a_bidir_neg: assert property (p_bidir_neg) else $error("negative polarity not applied");

  property p_input_only;
    @(posedge clk_i) disable iff (rst_i)
    (st.func[3:2] == cpfi_pkg::INPUT_ONLY_FUNCTION)[*2] |-> !pin_oe_o[1];
  endproperty
  a_input_only: assert property (p_input_only) else $error("input pin driven");

  property p_fault_return;
    @(posedge clk_i) disable iff (rst_i)
    (st.func[1:0] == cpfi_pkg::FAULT_OUT_FUNCTION)[*2] |->
    (!pin_oe_o[1] && pin_oe_o[0] && pin_o[0] == (st.fault ^ st.pol[0]));
  endproperty
  a_fault_return: assert property (p_fault_return) else $error("fault pin pair wrong");

  property p_fault_set;
    @(posedge clk_i) disable iff (rst_i)
    (|(ov_i | oc_i | ot_i)) |=> (st.fault && st.prot && chan_en_o == '0);
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not raised");

  property p_fault_hold;
    @(posedge clk_i) disable iff (rst_i)
    (st.prot && !clear_req) |=> st.prot;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("protection dropped uncleared");

  property p_clear_refused;
    @(posedge clk_i) disable iff (rst_i)
    (st.prot && inhibit_true) |=> st.prot;
  endproperty
  a_clear_refused: assert property (p_clear_refused) else $error("cleared under inhibit");

  property p_latch_edge;
    @(posedge clk_i) disable iff (rst_i)
    (st.mode == cpfi_pkg::INHIBIT_LATCHING_MODE && inhibit_true && !st.inhibit_prev) |=>
    (st.prot && chan_en_o == '0);
  endproperty
  a_latch_edge: assert property (p_latch_edge) else $error("latching inhibit missed");

  property p_live;
    @(posedge clk_i) disable iff (rst_i)
    (live_hold [*2]) |-> ##1 (chan_en_o == '0 && st.fault);
  endproperty
  a_live: assert property (p_live) else $error("live inhibit did not disable");

  property p_off_mode;
    @(posedge clk_i) disable iff (rst_i)
    (st.mode == cpfi_pkg::INHIBIT_OFF_MODE) |-> !inhibit_true;
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("off mode saw inhibit");

  property p_off_delay;
    @(posedge clk_i) disable iff (rst_i)
    st.off_wait < 32'(OFF_DELAY_CYC);
  endproperty
  a_off_delay: assert property (p_off_delay) else $error("outputs not off in time");
endmodule
`default_nettype wire

// ==== cpfi_pin_partner.sv ====
`default_nettype none
// Far side of the control port: relays, switches or a chained unit's fault line
module cpfi_pin_partner (
  input wire logic [2:0] dev_lvl_i,
  input wire logic [2:0] dev_oe_i,
  input wire logic [2:0] ext_lvl_i,
  input wire logic [2:0] ext_oe_i,
  output logic [2:0] pin_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Wire level per pin: device drive wins, then far side, else the pull-up
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      if (dev_oe_i[k]) begin
        pin_lvl_o[k] = dev_lvl_i[k];
      end else if (ext_oe_i[k]) begin
        pin_lvl_o[k] = ext_lvl_i[k];
      end else begin
        pin_lvl_o[k] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== control_port_fault_inhibit_tb.sv ====
`default_nettype none
module control_port_fault_inhibit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAT = 16;
  localparam int OFF = 64;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, nv_store_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rdata;
  logic [2:0] pin_i, pin_o, pin_oe_o, ext_lvl, ext_oe, pol, outw;
  logic [1:0] ov_i, oc_i, ot_i, chan_en_o, nv_mode_i, nv_mode_o;
  int n_mismatch, n_checks, n_store;

  cpfi_top #(.INHIBIT_LATENCY_CYC(LAT), .OFF_DELAY_CYC(OFF)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .ov_i(ov_i), .oc_i(oc_i),
    .ot_i(ot_i), .chan_en_o(chan_en_o), .nv_mode_i(nv_mode_i),
    .nv_mode_o(nv_mode_o), .nv_store_o(nv_store_o)
  );
  cpfi_pin_partner partner (
    .dev_lvl_i(pin_o), .dev_oe_i(pin_oe_o), .ext_lvl_i(ext_lvl),
    .ext_oe_i(ext_oe), .pin_lvl_o(pin_i)
  );

  // Clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Count store pulses of the mode setting
  always @(posedge clk_i) begin
    if (nv_store_o === 1'b1) n_store++;
  end

  // Electrical level for a logical bit under a polarity select
  function automatic logic [2:0] lvl_of(input logic [2:0] bits, input logic [2:0] p);
    return bits ^ p;
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One classic bus cycle; waits for ack, then releases for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rdata = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (n >= 50) chk("ack", 32'h0, 32'h1);
    @(posedge clk_i);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, rdata, e);
  endtask

  task automatic chk_chan(input logic [1:0] e);
    chk("chan_en", {30'h0, chan_en_o}, {30'h0, e});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end

  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    {ov_i, oc_i, ot_i, ext_lvl, ext_oe} = '0;
    nv_mode_i = 2'h2;
    n_mismatch = 0;
    n_checks = 0;
    n_store = 0;
    void'($urandom(31817));
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values, stored mode, unmapped place
    rdchk("func", cpfi_pkg::REG_FUNC, {26'h0, cpfi_pkg::FUNC_RST});
    rdchk("pol", cpfi_pkg::REG_POL, {29'h0, cpfi_pkg::POL_RST});
    rdchk("out", cpfi_pkg::REG_OUT, {29'h0, cpfi_pkg::OUT_RST});
    rdchk("mode", cpfi_pkg::REG_MODE, 32'h2);
    rdchk("unmapped", 8'hFC, 32'h0);
    $display("test reset done");
    // Bidirectional pins, random words and polarities
    for (int i = 0; i < 10; i++) begin
      pol = (i == 0) ? 3'h0 : 3'($urandom);
      outw = (i == 0) ? 3'h5 : 3'($urandom);
      wb(1'b1, cpfi_pkg::REG_POL, {29'h0, pol});
      wb(1'b1, cpfi_pkg::REG_OUT, {29'h0, outw});
      repeat (6) @(posedge clk_i);
      chk("pin_o", {29'h0, pin_o}, {29'h0, lvl_of(outw, pol)});
      chk("pin_oe", {29'h0, pin_oe_o}, 32'h7);
      rdchk("in_bidir", cpfi_pkg::REG_IN, {29'h0, outw});
    end
    $display("test bidir done");
    // Input-only pins driven from the far side
    ext_oe <= 3'h7;
    for (int i = 0; i < 10; i++) begin
      // Odd passes pick functions that illegal pins fall back from
      wb(1'b1, cpfi_pkg::REG_FUNC, i[0] ? 32'h2F : 32'h15);
      pol = 3'($urandom);
      ext_lvl <= 3'($urandom);
      wb(1'b1, cpfi_pkg::REG_POL, {29'h0, pol});
      wb(1'b1, cpfi_pkg::REG_OUT, 32'($urandom));
      repeat (6) @(posedge clk_i);
      chk("pin_oe_in", {29'h0, pin_oe_o}, 32'h0);
      rdchk("in_word", cpfi_pkg::REG_IN, {29'h0, lvl_of(ext_lvl, pol)});
    end
    ext_oe <= 3'h0;
    $display("test input done");
    // Fault output on pin 1 for each cause, both polarities
    wb(1'b1, cpfi_pkg::REG_CHAN, 32'h3);
    wb(1'b1, cpfi_pkg::REG_FUNC, 32'h02);
    for (int i = 0; i < 3; i++) begin
      pol = {2'h0, i[0]};
      wb(1'b1, cpfi_pkg::REG_POL, {29'h0, pol});
      repeat (3) @(posedge clk_i);
      chk_chan(2'h3);
      ov_i <= (i == 0) ? 2'h1 : 2'h0;
      oc_i <= (i == 1) ? 2'h2 : 2'h0;
      ot_i <= (i == 2) ? 2'h1 : 2'h0;
      repeat (3) @(posedge clk_i);
      chk_chan(2'h0);
      chk("fault_pin", {31'h0, pin_o[0]}, {31'h0, ~pol[0]});
      chk("ret_oe", {31'h0, pin_oe_o[1]}, 32'h0);
      wb(1'b1, cpfi_pkg::REG_CTRL, 32'h1);
      {ov_i, oc_i, ot_i} <= '0;
      repeat (3) @(posedge clk_i);
      chk_chan(2'h0);
      chk("fault_hold", {31'h0, pin_o[0]}, {31'h0, ~pol[0]});
      wb(1'b1, cpfi_pkg::REG_CTRL, 32'h1);
      repeat (2) @(posedge clk_i);
      chk_chan(2'h3);
      chk("fault_rel", {31'h0, pin_o[0]}, {31'h0, pol[0]});
    end
    $display("test fault done");
    // Inhibit on pin 3 through the shortcut, in live, latching and off modes
    ext_oe <= 3'h4;
    wb(1'b1, cpfi_pkg::REG_POL, 32'h4);
    wb(1'b1, cpfi_pkg::REG_CTRL, 32'h2);
    rdchk("pol_short", cpfi_pkg::REG_POL, 32'h0);
    rdchk("func_short", cpfi_pkg::REG_FUNC, 32'h32);
    for (int m = 2; m >= 0; m--) begin
      wb(1'b1, cpfi_pkg::REG_MODE, 32'(m));
      ext_lvl <= 3'h4;
      repeat (LAT + 8) @(posedge clk_i);
      chk_chan((m == 0) ? 2'h3 : 2'h0);
      chk("inh_fault", {31'h0, pin_o[0]}, {31'h0, m != 0});
      ext_lvl <= 3'h0;
      repeat (LAT + 8) @(posedge clk_i);
      chk_chan((m == 1) ? 2'h0 : 2'h3);
      wb(1'b1, cpfi_pkg::REG_CTRL, 32'h1);
      repeat (2) @(posedge clk_i);
      chk_chan(2'h3);
    end
    // Negative polarity: shorting pin 3 to common is inhibit true
    wb(1'b1, cpfi_pkg::REG_POL, 32'h4);
    wb(1'b1, cpfi_pkg::REG_MODE, 32'h2);
    ext_lvl <= 3'h4;
    repeat (LAT + OFF) @(posedge clk_i);
    chk_chan(2'h3);
    ext_lvl <= 3'h0;
    repeat (LAT + OFF) @(posedge clk_i);
    chk_chan(2'h0);
    chk("nv_mode", {30'h0, nv_mode_o}, 32'h2);
    chk("nv_store", 32'(n_store), 32'h4);
    $display("test inhibit done");
    summarize();
  end
endmodule
`default_nettype wire
